// ---- ccemc_pkg.sv ----
// constants and types shared by the charge counter and energy mode block
//
// How it works
// - threshold field bits 6:5 selects 50, 62.5, 75 or 87.5 percent of full count.
// - the full flag rises when any one counter reaches the threshold.
// - bit 4 enables all counters together; clear leaves all disabled.
// - prescaler bits 3:2 apply to every counter and to nothing else.
// - one counter step equals 2 to the power (16 - 2*prescaler) pulses.
// - bits 7, 6, 5 enable the third, second, first coarse regulator in deepest mode.
// - bit 4 shorts every enabled coarse regulator output to the battery rail.
// - with forced wake set, any bus start moves the device to active mode.
// - mode select bits 2:1, reset zero, choose the mode outside direct mode.
// - a forced wake leaves the mode select field reading what was written.
package ccemc_pkg;

   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [7:0] CCEMC_CHARGE_COUNTER_CONTROL_OFS   = 8'h41;
   localparam logic [7:0] CCEMC_EM_CTRL_OFS   = 8'h43;
   localparam logic [7:0] CCEMC_CHARGE_COUNTER_CONTROL_RST   = 8'h00;
   localparam logic [7:0] CCEMC_EM_CTRL_RST   = 8'h00;
   localparam logic [7:0] CCEMC_CHARGE_COUNTER_CONTROL_WMASK = 8'h7c;
   localparam logic [7:0] CCEMC_UNMAPPED_DATA = 8'h00;

   localparam int CCEMC_THR_MSB   = 6;
   localparam int CCEMC_THR_LSB   = 5;
   localparam int CCEMC_EN_BIT    = 4;
   localparam int CCEMC_PRE_MSB   = 3;
   localparam int CCEMC_PRE_LSB   = 2;
   localparam int CCEMC_COARSE_MSB = 7;
   localparam int CCEMC_COARSE_LSB = 5;
   localparam int CCEMC_BYP_BIT   = 4;
   localparam int CCEMC_FORCE_BIT = 3;
   localparam int CCEMC_SEL_MSB   = 2;
   localparam int CCEMC_SEL_LSB   = 1;
   localparam int CCEMC_DIRECT_BIT = 0;

   // value is arbitrary
   localparam logic [6:0] CCEMC_I2C_ADDR = 7'h2a;

   // ***************************************************
   // counters
   // ***************************************************
   localparam int          CCEMC_NUM_CNT  = 3;
   localparam int          CCEMC_CNT_W    = 16;
   localparam logic [15:0] CCEMC_PRE_FULL = 16'hffff;
   localparam logic [15:0] CCEMC_CNT_MAX  = 16'hffff;
   localparam logic [3:0]  CCEMC_BITS_PER_BYTE = 4'h8;

   // ***************************************************
   // types
   // ***************************************************
   typedef enum logic [1:0] {
      CCEMC_ACTIVE_ENERGY_MODE  = 2'b00,
      CCEMC_LIGHT_ENERGY_MODE   = 2'b01,
      CCEMC_SLEEP_ENERGY_MODE   = 2'b10,
      CCEMC_DEEPEST_ENERGY_MODE = 2'b11
   } ccemc_mode_type;

   typedef enum logic [3:0] {
      CCEMC_IDLE  = 4'b0000,
      CCEMC_ADDR  = 4'b0001,
      CCEMC_AACK  = 4'b0010,
      CCEMC_PTR   = 4'b0011,
      CCEMC_PACK  = 4'b0100,
      CCEMC_WDATA = 4'b0101,
      CCEMC_WACK  = 4'b0110,
      CCEMC_RDATA = 4'b0111,
      CCEMC_RACK  = 4'b1000
   } ccemc_bus_state_type;

endpackage

// ---- ccemc_cfg_if.sv ----
// counter configuration and status between register bank and counters
`timescale 1ns/100ps
`default_nettype none
interface ccemc_cfg_if;
   logic       counters_enable;
   logic [1:0] counter_prescaler;
   logic [1:0] counter_full_threshold;
   logic       counter_full_flag;

   modport regs (
      output counters_enable,
      output counter_prescaler,
      output counter_full_threshold,
      input  counter_full_flag
   );
   modport counter (
      input  counters_enable,
      input  counter_prescaler,
      input  counter_full_threshold,
      output counter_full_flag
   );
endinterface
`default_nettype wire

// ---- ccemc_counters.sv ----
// charge counters with prescaler and full threshold detection
`timescale 1ns/100ps
`default_nettype none
module ccemc_counters
   import ccemc_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     nrst,
   ccemc_cfg_if.counter                  cfg,
   input  wire logic [CCEMC_NUM_CNT-1:0] converter_pulse
);

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [CCEMC_NUM_CNT-1:0][2:0]             sync;
      logic [CCEMC_NUM_CNT-1:0]                  filt;
      logic [CCEMC_NUM_CNT-1:0][CCEMC_CNT_W-1:0] pre;
      logic [CCEMC_NUM_CNT-1:0][CCEMC_CNT_W-1:0] cnt;
      logic                                      full;
   } ccemc_cnt_state_type;

   ccemc_cnt_state_type     r;
   ccemc_cnt_state_type     next_r;
   logic [CCEMC_CNT_W-1:0]  lim;
   logic [CCEMC_CNT_W-1:0]  thr;
   logic [CCEMC_NUM_CNT-1:0] pulse;
   logic [CCEMC_NUM_CNT-1:0] reach;

   // pulses per step minus one; calibration never sees this
   assign lim = CCEMC_PRE_FULL >> {cfg.counter_prescaler, 1'b0};
   // 50/62.5/75/87.5 percent of full count
   assign thr = {1'b1, cfg.counter_full_threshold, 13'h0000};

   genvar gi;
   generate
      for (gi = 0; gi < CCEMC_NUM_CNT; gi++) begin : g_ch
         assign pulse[gi] = (r.sync[gi][1] == r.sync[gi][2]) &&
                            r.sync[gi][2] && !r.filt[gi];
         assign reach[gi] = r.cnt[gi] >= thr;
      end
   endgenerate

   always_comb begin
      next_r = r;
      for (int i = 0; i < CCEMC_NUM_CNT; i++) begin
         next_r.sync[i] = {r.sync[i][1:0], converter_pulse[i]};
         if (r.sync[i][1] == r.sync[i][2]) begin
            next_r.filt[i] = r.sync[i][2];
         end
         // one enable for all counters
         if (cfg.counters_enable && pulse[i]) begin
            if (r.pre[i] >= lim) begin
               next_r.pre[i] = '0;
               if (r.cnt[i] != CCEMC_CNT_MAX) begin
                  next_r.cnt[i] = r.cnt[i] + 16'h0001;
               end
            end else begin
               next_r.pre[i] = r.pre[i] + 16'h0001;
            end
         end
      end
      next_r.full = |reach;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign cfg.counter_full_flag = r.full;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   threshold_hit_a: assert property (
      (r.cnt[0] >= {1'b1, cfg.counter_full_threshold, 13'h0000}) |=> r.full)
      else $error("full flag missed threshold");
   any_counter_a: assert property (
      (r.cnt[1] >= thr && r.cnt[0] < thr && r.cnt[2] < thr) |=> r.full)
      else $error("single counter did not raise full");
   below_clear_a: assert property (
      (reach == '0) |=> !r.full)
      else $error("full flag set below threshold");
   disabled_hold_a: assert property (
      !cfg.counters_enable |=> $stable(r.cnt) && $stable(r.pre))
      else $error("counter moved while disabled");
   prescale_step_a: assert property (
      (cfg.counters_enable && pulse[0] && r.pre[0] == lim &&
       r.cnt[0] != CCEMC_CNT_MAX) |=> r.cnt[0] == $past(r.cnt[0]) + 16'h0001)
      else $error("counter missed prescaled step");
   no_early_step_a: assert property (
      (r.pre[0] < lim) |=> r.cnt[0] == $past(r.cnt[0]))
      else $error("counter stepped before prescale");

   counter_full_c: cover property (!r.full ##1 r.full);

endmodule
`default_nettype wire

// ---- ccemc_top.sv ----
// i2c target, control registers and energy mode logic
`timescale 1ns/100ps
`default_nettype none
module ccemc_top
   import ccemc_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic                     scl_in,
   input  wire logic                     sda_in,
   output logic                          sda_out,
   output logic                          sda_oe,
   input  wire logic [CCEMC_NUM_CNT-1:0] converter_pulse,
   input  wire logic [1:0]               direct_mode_pins,
   output logic [1:0]                    energy_mode,
   output logic                          first_output_coarse_enable,
   output logic                          second_output_coarse_enable,
   output logic                          third_output_coarse_enable,
   output logic [2:0]                    battery_rail_switch,
   output logic                          counter_full_flag
);

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [2:0]          scl_sync;
      logic [2:0]          sda_sync;
      logic                scl_f;
      logic                sda_f;
      ccemc_bus_state_type st;
      logic [3:0]          bitn;
      logic [7:0]          shreg;
      logic [7:0]          ptr;
      logic                rw;
      logic                nack;
      logic                drive;
      logic [7:0]          charge_counter_control;
      logic [7:0]          em_ctrl;
      logic [2:0][1:0]     dm_sync;
      logic [1:0]          dm_f;
      ccemc_mode_type      mode;
      logic [2:0]          coarse;
      logic [2:0]          bypass;
   } ccemc_regs_state_type;

   ccemc_regs_state_type r;
   ccemc_regs_state_type next_r;
   ccemc_cfg_if          cfg_bus ();

   logic       scl_new;
   logic       sda_new;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_evt;
   logic       stop_evt;
   logic [7:0] rdv;
   logic       wr_em;
   logic [7:0] wdata;
   logic       dm_change;
   logic [1:0] dm_new;
   logic       sel_ok;

   // ***************************************************
   // pin filtering
   // ***************************************************
   // level accepted only when the two later stages agree
   always_comb begin
      scl_new = (r.scl_sync[1] == r.scl_sync[2]) ? r.scl_sync[2] : r.scl_f;
      sda_new = (r.sda_sync[1] == r.sda_sync[2]) ? r.sda_sync[2] : r.sda_f;
      dm_change = (r.dm_sync[1] == r.dm_sync[2]) && (r.dm_sync[2] != r.dm_f);
      dm_new = dm_change ? r.dm_sync[2] : r.dm_f;
   end

   assign scl_rise  = !r.scl_f && scl_new;
   assign scl_fall  = r.scl_f && !scl_new;
   assign start_evt = r.scl_f && scl_new && r.sda_f && !sda_new;
   assign stop_evt  = r.scl_f && scl_new && !r.sda_f && sda_new;

   // ***************************************************
   // register read mux
   // ***************************************************
   always_comb begin
      unique case (r.ptr)
         CCEMC_CHARGE_COUNTER_CONTROL_OFS: rdv = r.charge_counter_control;
         CCEMC_EM_CTRL_OFS: rdv = r.em_ctrl;
         default:           rdv = CCEMC_UNMAPPED_DATA;
      endcase
   end

   // ***************************************************
   // bus target, registers, mode
   // ***************************************************
   always_comb begin
      next_r = r;
      wr_em  = 1'b0;
      wdata  = r.shreg;
      next_r.scl_sync = {r.scl_sync[1:0], scl_in};
      next_r.sda_sync = {r.sda_sync[1:0], sda_in};
      next_r.dm_sync  = {r.dm_sync[1:0], direct_mode_pins};
      next_r.scl_f    = scl_new;
      next_r.sda_f    = sda_new;
      next_r.dm_f     = dm_new;

      if (start_evt) begin
         next_r.st    = CCEMC_ADDR;
         next_r.bitn  = '0;
         next_r.drive = 1'b0;
      end else if (stop_evt) begin
         next_r.st    = CCEMC_IDLE;
         next_r.drive = 1'b0;
      end else if (scl_rise) begin
         unique case (r.st)
            CCEMC_ADDR, CCEMC_PTR, CCEMC_WDATA: begin
               next_r.shreg = {r.shreg[6:0], sda_new};
               next_r.bitn  = r.bitn + 4'h1;
            end
            CCEMC_RDATA: begin
               next_r.bitn = r.bitn + 4'h1;
            end
            CCEMC_RACK: begin
               next_r.nack = sda_new;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (r.st)
            CCEMC_ADDR: begin
               if (r.bitn == CCEMC_BITS_PER_BYTE) begin
                  if (r.shreg[7:1] == CCEMC_I2C_ADDR) begin
                     next_r.st    = CCEMC_AACK;
                     next_r.rw    = r.shreg[0];
                     next_r.drive = 1'b1;
                  end else begin
                     next_r.st = CCEMC_IDLE;
                  end
               end
            end
            CCEMC_AACK: begin
               next_r.bitn = '0;
               if (r.rw) begin
                  next_r.st    = CCEMC_RDATA;
                  next_r.shreg = rdv;
                  next_r.drive = !rdv[7];
                  next_r.ptr   = r.ptr + 8'h01;
               end else begin
                  next_r.st    = CCEMC_PTR;
                  next_r.drive = 1'b0;
               end
            end
            CCEMC_PTR: begin
               if (r.bitn == CCEMC_BITS_PER_BYTE) begin
                  next_r.ptr   = r.shreg;
                  next_r.st    = CCEMC_PACK;
                  next_r.drive = 1'b1;
               end
            end
            CCEMC_WDATA: begin
               if (r.bitn == CCEMC_BITS_PER_BYTE) begin
                  // reserved counter bits are dropped and read zero
                  if (r.ptr == CCEMC_CHARGE_COUNTER_CONTROL_OFS) begin
                     next_r.charge_counter_control = r.shreg & CCEMC_CHARGE_COUNTER_CONTROL_WMASK;
                  end
                  if (r.ptr == CCEMC_EM_CTRL_OFS) begin
                     next_r.em_ctrl = r.shreg;
                     wr_em = 1'b1;
                  end
                  next_r.ptr   = r.ptr + 8'h01;
                  next_r.st    = CCEMC_WACK;
                  next_r.drive = 1'b1;
               end
            end
            CCEMC_PACK, CCEMC_WACK: begin
               next_r.st    = CCEMC_WDATA;
               next_r.bitn  = '0;
               next_r.drive = 1'b0;
            end
            CCEMC_RDATA: begin
               if (r.bitn == CCEMC_BITS_PER_BYTE) begin
                  next_r.st    = CCEMC_RACK;
                  next_r.drive = 1'b0;
               end else begin
                  next_r.shreg = {r.shreg[6:0], 1'b0};
                  next_r.drive = !r.shreg[6];
               end
            end
            CCEMC_RACK: begin
               if (r.nack) begin
                  next_r.st = CCEMC_IDLE;
               end else begin
                  next_r.st    = CCEMC_RDATA;
                  next_r.bitn  = '0;
                  next_r.shreg = rdv;
                  next_r.drive = !rdv[7];
                  next_r.ptr   = r.ptr + 8'h01;
               end
            end
            default: begin
            end
         endcase
      end

      // mode: wake on start beats pins and register writes
      if (start_evt && r.em_ctrl[CCEMC_FORCE_BIT]) begin
         // select field is left alone, so it may read 2 while active
         next_r.mode = CCEMC_ACTIVE_ENERGY_MODE;
      end else if (next_r.em_ctrl[CCEMC_DIRECT_BIT]) begin
         if (dm_change || wr_em) begin
            next_r.mode = ccemc_mode_type'(dm_new);
         end
      end else if (wr_em) begin
         next_r.mode = ccemc_mode_type'(
            wdata[CCEMC_SEL_MSB:CCEMC_SEL_LSB]);
      end

      // coarse regulators live only in the deepest mode
      next_r.coarse = r.em_ctrl[CCEMC_COARSE_MSB:CCEMC_COARSE_LSB] &
         {3{r.mode == CCEMC_DEEPEST_ENERGY_MODE}};
      next_r.bypass = next_r.coarse &
         {3{r.em_ctrl[CCEMC_BYP_BIT]}};
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r         <= '0;
         r.charge_counter_control <= CCEMC_CHARGE_COUNTER_CONTROL_RST;
         r.em_ctrl <= CCEMC_EM_CTRL_RST;
      end else begin
         r <= next_r;
      end
   end

   // ***************************************************
   // outputs and counters
   // ***************************************************
   assign cfg_bus.counters_enable        = r.charge_counter_control[CCEMC_EN_BIT];
   assign cfg_bus.counter_prescaler      =
      r.charge_counter_control[CCEMC_PRE_MSB:CCEMC_PRE_LSB];
   assign cfg_bus.counter_full_threshold =
      r.charge_counter_control[CCEMC_THR_MSB:CCEMC_THR_LSB];

   ccemc_counters u_counters (
      .clk             (clk),
      .nrst            (nrst),
      .cfg             (cfg_bus),
      .converter_pulse (converter_pulse)
   );

   assign counter_full_flag           = cfg_bus.counter_full_flag;
   assign sda_out                     = 1'b0;
   assign sda_oe                      = r.drive;
   assign energy_mode                 = r.mode;
   assign first_output_coarse_enable  = r.coarse[0];
   assign second_output_coarse_enable = r.coarse[1];
   assign third_output_coarse_enable  = r.coarse[2];
   assign battery_rail_switch         = r.bypass;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   assign sel_ok = !start_evt || !r.em_ctrl[CCEMC_FORCE_BIT];

   coarse_off_a: assert property (
      (r.mode != CCEMC_DEEPEST_ENERGY_MODE) |=> (r.coarse == 3'h0))
      else $error("coarse regulator on outside deepest mode");
   coarse_on_a: assert property (
      (r.mode == CCEMC_DEEPEST_ENERGY_MODE && r.em_ctrl[7]) |=> r.coarse[2])
      else $error("third coarse regulator not enabled");
   bypass_switch_a: assert property (
      r.bypass == (r.coarse & {3{$past(r.em_ctrl[CCEMC_BYP_BIT])}}))
      else $error("battery rail switch mismatch");
   forced_wake_a: assert property (
      (start_evt && r.em_ctrl[CCEMC_FORCE_BIT]) |=>
         r.mode == CCEMC_ACTIVE_ENERGY_MODE)
      else $error("start did not wake device");
   no_wake_a: assert property (
      (!r.em_ctrl[CCEMC_FORCE_BIT] && !r.em_ctrl[0] && !wr_em) |=>
         $stable(r.mode))
      else $error("mode changed without cause");
   sel_write_a: assert property (
      (wr_em && !wdata[0] && sel_ok) |=> r.mode == $past(wdata[2:1]))
      else $error("mode select not applied");
   sel_kept_a: assert property (
      (start_evt && r.em_ctrl[CCEMC_FORCE_BIT] && r.em_ctrl[2:1] == 2'h2)
         |=> (r.em_ctrl[2:1] == 2'h2) [*2])
      else $error("select field disturbed by wake");
   direct_follow_a: assert property (
      (dm_change && r.em_ctrl[0] && sel_ok && !wr_em) |=>
         r.mode == $past(dm_new))
      else $error("direct mode pins not followed");
   cc_reserved_a: assert property (
      r.charge_counter_control[7] == 1'b0 && r.charge_counter_control[1:0] == 2'h0)
      else $error("reserved counter bits set");

   address_ack_c: cover property (r.st == CCEMC_AACK && r.drive);
   em_write_c: cover property (wr_em);
   forced_wake_c: cover property (start_evt && r.em_ctrl[CCEMC_FORCE_BIT]
                                  && r.em_ctrl[2:1] == 2'h2);
   deepest_c: cover property (r.coarse != 3'h0 && r.bypass != 3'h0);

endmodule
`default_nettype wire

// ---- ccemc_host.sv ----
// i2c controller model standing in for the host processor
`timescale 1ns/100ps
`default_nettype none
module ccemc_host
   import ccemc_pkg::*;
(
   output logic      scl,
   output logic      sda_rel,
   input  wire logic sda_line
);
   // quarter of the 320 ns scl period; scl stands high between frames
   localparam time Q = 80ns;

   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   task automatic start();
      sda_rel = 1'b1;
      #Q scl = 1'b1;
      #Q sda_rel = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask

   task automatic stop();
      sda_rel = 1'b0;
      #Q scl = 1'b1;
      #Q sda_rel = 1'b1;
      #(2*Q);
   endtask

   // sample late in the high phase, device answers ~4 clk after the fall
   task automatic xbit(input logic b, output logic r);
      sda_rel = b;
      #Q scl = 1'b1;
      #(Q+Q/2) r = sda_line;
      #(Q/2) scl = 1'b0;
      #Q;
   endtask

   task automatic byte_io(input logic [7:0] d, input logic ai,
                          output logic [7:0] r, output logic ao);
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], r[i]);
      end
      xbit(ai, ao);
   endtask

   task automatic write(input logic [7:0] ofs, input logic [7:0] d,
                        output logic nack);
      logic [7:0] r;
      logic a0, a1, a2;
      start();
      byte_io({CCEMC_I2C_ADDR, 1'b0}, 1'b1, r, a0);
      byte_io(ofs, 1'b1, r, a1);
      byte_io(d, 1'b1, r, a2);
      stop();
      nack = a0 | a1 | a2;
   endtask

   // last byte is refused by the host so the device lets go of sda
   task automatic read(input logic [7:0] ofs, output logic [7:0] d,
                       output logic nack);
      logic [7:0] r;
      logic a0, a1, a2, a3;
      start();
      byte_io({CCEMC_I2C_ADDR, 1'b0}, 1'b1, r, a0);
      byte_io(ofs, 1'b1, r, a1);
      start();
      byte_io({CCEMC_I2C_ADDR, 1'b1}, 1'b1, r, a2);
      byte_io(8'hff, 1'b1, d, a3);
      stop();
      nack = a0 | a1 | a2;
   endtask
endmodule
`default_nettype wire

// ---- ccemc_top_tb.sv ----
// self-checking bench for the control register block
`timescale 1ns/100ps
`default_nettype none
module ccemc_top_tb
   import ccemc_pkg::*;
;
   logic                     clk, nrst, scl, sda_rel, sda_line;
   logic                     sda_out, sda_oe, c1, c2, c3, counter_full_flag;
   logic [CCEMC_NUM_CNT-1:0] converter_pulse;
   logic [1:0]               direct_mode_pins, energy_mode;
   logic [2:0]               battery_rail_switch;
   logic                     nack;
   logic [7:0]               rdata;
   int                       n_mismatch, check_count;

   // open drain with pull-up
   assign sda_line = sda_rel & ~(sda_oe & ~sda_out);

   ccemc_host ccemc_host_i (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));

   ccemc_top ccemc_top_i (
      .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .converter_pulse(converter_pulse),
      .direct_mode_pins(direct_mode_pins), .energy_mode(energy_mode),
      .first_output_coarse_enable(c1), .second_output_coarse_enable(c2),
      .third_output_coarse_enable(c3),
      .battery_rail_switch(battery_rail_switch),
      .counter_full_flag(counter_full_flag)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ************************************
   // compare and bus helpers
   // ************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_out(input logic [1:0] m, input logic [2:0] co,
                          input logic [2:0] sw);
      chk({6'h00, energy_mode}, {6'h00, m}, "mode");
      chk({5'h00, c3, c2, c1}, {5'h00, co}, "coarse");
      chk({5'h00, battery_rail_switch}, {5'h00, sw}, "switch");
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      @(posedge clk);
      #1 ccemc_host_i.write(ofs, d, nack);
      chk({7'h00, nack}, 8'h00, "write ack");
      repeat (4) @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
      @(posedge clk);
      #1 ccemc_host_i.read(ofs, rdata, nack);
      chk({7'h00, nack}, 8'h00, "read ack");
      chk(rdata, exp, "read data");
      repeat (4) @(posedge clk);
   endtask

   // counters have no pins of their own, so their state is read inside
   task automatic chk_cnt(input logic [15:0] c, input logic [15:0] p);
      logic [15:0] gc;
      logic [15:0] gp;
      for (int i = 0; i < CCEMC_NUM_CNT; i++) begin
         gc = ccemc_top_i.u_counters.r.cnt[i];
         gp = ccemc_top_i.u_counters.r.pre[i];
         chk(gc[15:8], c[15:8], "count");
         chk(gc[7:0], c[7:0], "count");
         chk(gp[15:8], p[15:8], "prescale");
         chk(gp[7:0], p[7:0], "prescale");
      end
   endtask

   // four clocks per phase, above the two the synchroniser needs
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         #1 converter_pulse = '1;
         repeat (4) @(posedge clk);
         #1 converter_pulse = '0;
         repeat (3) @(posedge clk);
      end
   endtask

   // ************************************
   // scenarios
   // ************************************
   task automatic t_reset();
      rd(CCEMC_CHARGE_COUNTER_CONTROL_OFS, 8'h00);
      rd(CCEMC_EM_CTRL_OFS, 8'h00);
      rd(8'h42, CCEMC_UNMAPPED_DATA);
      chk_out(2'd0, 3'b000, 3'b000);
      chk_cnt(16'h0000, 16'h0000);
   endtask

   task automatic t_counter();
      wr(CCEMC_CHARGE_COUNTER_CONTROL_OFS, 8'hff);
      rd(CCEMC_CHARGE_COUNTER_CONTROL_OFS, 8'h7c);
      for (int t = 0; t < 4; t++) begin
         wr(CCEMC_CHARGE_COUNTER_CONTROL_OFS, {1'b0, t[1:0], 1'b1, 2'b11, 2'b00});
         rd(CCEMC_CHARGE_COUNTER_CONTROL_OFS, {1'b0, t[1:0], 1'b1, 2'b11, 2'b00});
      end
      // prescaler 3: one step every 2^10 pulses
      pulses(1023);
      chk_cnt(16'h0000, 16'h03ff);
      pulses(1);
      chk_cnt(16'h0001, 16'h0000);
      wr(CCEMC_CHARGE_COUNTER_CONTROL_OFS, 8'h6c);
      pulses(4);
      chk_cnt(16'h0001, 16'h0000);
      chk({7'h00, counter_full_flag}, 8'h00, "flag");
   endtask

   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wr(CCEMC_EM_CTRL_OFS, {3'b111, 2'b00, m[1:0], 1'b0});
         chk_out(m[1:0], (m == 3) ? 3'b111 : 3'b000, 3'b000);
      end
      wr(CCEMC_EM_CTRL_OFS, 8'hb6);
      chk_out(2'd3, 3'b101, 3'b101);
   endtask

   task automatic t_wake();
      logic [7:0] r;
      wr(CCEMC_EM_CTRL_OFS, 8'h0c);
      chk_out(2'd2, 3'b000, 3'b000);
      rd(CCEMC_EM_CTRL_OFS, 8'h0c);
      chk_out(2'd0, 3'b000, 3'b000);
      wr(CCEMC_EM_CTRL_OFS, 8'h0c);
      chk_out(2'd2, 3'b000, 3'b000);
      // a start to another address still wakes the device
      @(posedge clk);
      #1 ccemc_host_i.start();
      ccemc_host_i.byte_io(8'h56, 1'b1, r, nack);
      ccemc_host_i.stop();
      chk({7'h00, nack}, 8'h01, "foreign ack");
      chk_out(2'd0, 3'b000, 3'b000);
   endtask

   task automatic t_direct();
      @(posedge clk);
      #1 direct_mode_pins = 2'b11;
      wr(CCEMC_EM_CTRL_OFS, 8'h09);
      chk_out(2'd3, 3'b000, 3'b000);
      @(posedge clk);
      #1 direct_mode_pins = 2'b01;
      repeat (8) @(posedge clk);
      chk_out(2'd1, 3'b000, 3'b000);
      wr(CCEMC_EM_CTRL_OFS, 8'h04);
      chk_out(2'd2, 3'b000, 3'b000);
   endtask

   // reset in mid-run must bring back every reset value
   task automatic t_midreset();
      @(posedge clk);
      #1 nrst = 1'b0;
      repeat (3) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
   endtask

   task automatic summarize();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #2ms;
      n_mismatch++;
      summarize();
   end

   initial begin
      nrst = 1'b0;
      converter_pulse = '0;
      direct_mode_pins = 2'b00;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
      t_counter();
      t_modes();
      t_wake();
      t_direct();
      t_midreset();
      summarize();
   end
endmodule
`default_nettype wire
